// >>> common/pattern_pkg.sv
// Constants, register map and carrier types of the timing pattern output block
// Assumes a 32-bit classic Wishbone slave port and a single 200 MHz sys_clk
//
// Summary of operation
// - Pin driven when function 11 and enabled
// - Selected trigger copies staged pattern into latch
// - Up to 16 bits update per trigger
// - Gap group: match A copies all enabled bits
// - Gap group: match B copies only zeros
// - Falls on B, rises delayed to A
// - Capture strobe triggers like compare A
// - Refill by DMA or interrupt routine writes
// - Mask F8 limits updates to five pins
// - Four-phase test: FF, gap groups, 95
// - Two-bit select picks channel, resets to 3
// - Disabled bits never transfer, hold value
// - Ordinary group ignores compare B
package pattern_pkg;

    localparam int unsigned NUM_BITS = 16;
    localparam int unsigned GRP_W    = 4;
    localparam int unsigned NUM_GRP  = 4;
    localparam int unsigned NUM_CH   = 4;

    // Byte offsets of the registers
    localparam logic [7:0] OFS_LATCH    = 8'h00;
    localparam logic [7:0] OFS_FUNC_UP  = 8'h04;
    localparam logic [7:0] OFS_FUNC_LO  = 8'h08;
    localparam logic [7:0] OFS_ENABLE   = 8'h0C;
    localparam logic [7:0] OFS_STAGED   = 8'h10;
    localparam logic [7:0] OFS_TRIG_SEL = 8'h14;
    localparam logic [7:0] OFS_GAP_MODE = 8'h18;
    localparam logic [7:0] OFS_PINS     = 8'h1C;
    localparam logic [7:0] OFS_XFER_CNT = 8'h20;

    // Values after reset
    localparam logic [15:0] RST_LATCH    = 16'h0000;
    localparam logic [15:0] RST_FUNC     = 16'h0000;
    localparam logic [15:0] RST_ENABLE   = 16'h0000;
    localparam logic [15:0] RST_STAGED   = 16'h0000;
    localparam logic [7:0]  RST_TRIG_SEL = 8'hFF;
    localparam logic [3:0]  RST_GAP_MODE = 4'h0;
    localparam logic [15:0] RST_XFER_CNT = 16'h0000;

    // Upper nibble of the mode register always reads as ones
    localparam logic [3:0]  GAP_MODE_RSVD = 4'hF;
    localparam logic [1:0]  FUNC_PATTERN  = 2'b11;
    localparam logic [31:0] RDATA_NONE    = 32'h0000_0000;

    typedef struct packed {
        logic [NUM_CH-1:0] match_a;
        logic [NUM_CH-1:0] match_b;
        logic [NUM_CH-1:0] capture_a;
    } timer_evt_t;

    typedef struct packed {
        logic [NUM_BITS-1:0] level;
        logic [NUM_BITS-1:0] oe;
    } pattern_pins_t;

    typedef struct packed {
        logic [15:0] latch;
        logic [15:0] func_up;
        logic [15:0] func_lo;
        logic [15:0] enable;
        logic [15:0] staged;
        logic [7:0]  trig_sel;
        logic [3:0]  gap_mode;
        logic [15:0] oe;
        logic [15:0] xfer_cnt;
        logic        ack;
        logic [31:0] rdata;
    } unit_state_t;

    localparam unit_state_t UNIT_RST = '{
        latch:    RST_LATCH,
        func_up:  RST_FUNC,
        func_lo:  RST_FUNC,
        enable:   RST_ENABLE,
        staged:   RST_STAGED,
        trig_sel: RST_TRIG_SEL,
        gap_mode: RST_GAP_MODE,
        oe:       RST_ENABLE,
        xfer_cnt: RST_XFER_CNT,
        ack:      1'b0,
        rdata:    RDATA_NONE
    };

endpackage : pattern_pkg

// >>> hdl/pattern_group.sv
// One output group: next value of its latch bits for the current triggers
// Assumes trigger strobes already chosen for this group's channel
`timescale 1ns/1ps
module pattern_group #(
    parameter int unsigned W = 4
) (
    input  wire logic [W-1:0] latch,
    input  wire logic [W-1:0] staged,
    input  wire logic [W-1:0] enable,
    input  wire logic         gap_mode,
    input  wire logic         hit_a,
    input  wire logic         hit_b,
    output logic      [W-1:0] latch_nxt,
    output logic              moved
);

    always_comb begin
        latch_nxt = latch;
        moved     = 1'b0;
        if (hit_a) begin
            // Match A wins when both land together
            latch_nxt = (latch & ~enable) | (staged & enable);
            moved     = 1'b1;
        end else if (hit_b && gap_mode) begin
            // Only zeros fall early; ones wait for match A
            latch_nxt = latch & ~(enable & ~staged);
            moved     = 1'b1;
        end
    end

endmodule : pattern_group

// >>> hdl/pattern_output_unit.sv
// Timing pattern output unit with its register file on classic Wishbone
// Assumes timer strobes are one-cycle pulses on sys_clk, no synchroniser needed
`timescale 1ns/1ps
module pattern_output_unit
    import pattern_pkg::*;
(
    input  wire logic          sys_clk,
    input  wire logic          rst_n,
    input  wire logic          wb_cyc_i,
    input  wire logic          wb_stb_i,
    input  wire logic          wb_we_i,
    input  wire logic [7:0]    wb_adr_i,
    input  wire logic [3:0]    wb_sel_i,
    input  wire logic [31:0]   wb_dat_i,
    output logic      [31:0]   wb_dat_o,
    output logic               wb_ack_o,
    input  wire timer_evt_t    timer_evt,
    output pattern_pins_t      pins
);

    unit_state_t         s_r;
    unit_state_t         s_nxt;
    logic                req;
    logic                wr;
    logic                rd;
    logic [15:0]         bus_latch;
    logic [15:0]         grp_latch;
    logic [NUM_GRP-1:0]  grp_moved;
    logic [NUM_CH-1:0]   trig_a;
    logic [15:0]         func_on;

    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge16(
        input logic [15:0] old,
        input logic [31:0] dat,
        input logic [3:0]  sel
    );
        logic [15:0] res;
        res = old;
        if (sel[0]) begin
            res[7:0] = dat[7:0];
        end
        if (sel[1]) begin
            res[15:8] = dat[15:8];
        end
        return res;
    endfunction : merge16

    // Byte-lane merge of an 8-bit register
    function automatic logic [7:0] merge8(
        input logic [7:0]  old,
        input logic [31:0] dat,
        input logic [3:0]  sel
    );
        logic [7:0] res;
        res = old;
        if (sel[0]) begin
            res = dat[7:0];
        end
        return res;
    endfunction : merge8

    // Pins whose two-bit function field holds the pattern code
    function automatic logic [15:0] pattern_func(
        input logic [15:0] up,
        input logic [15:0] lo
    );
        logic [15:0] res;
        res = 16'h0000;
        for (int k = 0; k < 8; k++) begin
            res[k]     = (lo[2*k +: 2] == FUNC_PATTERN);
            res[k + 8] = (up[2*k +: 2] == FUNC_PATTERN);
        end
        return res;
    endfunction : pattern_func

    // One answer per request; ack drops the cycle after it rose
    assign req = wb_cyc_i & wb_stb_i & ~s_r.ack;
    assign wr  = req & wb_we_i;
    assign rd  = req & ~wb_we_i;

    // Capture on register A stands in for compare A
    assign trig_a = timer_evt.match_a | timer_evt.capture_a;

    assign func_on = pattern_func(s_r.func_up, s_r.func_lo);

    // Software write to the latch first; a trigger on the same edge
    // overrides the enabled bits it moves
    always_comb begin
        bus_latch = s_r.latch;
        if (wr && wb_adr_i == OFS_LATCH) begin
            bus_latch = merge16(s_r.latch, wb_dat_i, wb_sel_i);
        end
    end

    // Each group picks its own channel and mode
    for (genvar g = 0; g < NUM_GRP; g++) begin : g_grp
        logic [1:0] ch;
        logic       hit_a;
        logic       hit_b;

        assign ch    = s_r.trig_sel[2*g +: 2];
        assign hit_a = trig_a[ch];
        assign hit_b = timer_evt.match_b[ch];

        pattern_group #(
            .W (GRP_W)
        ) u_grp (
            .latch     (bus_latch[GRP_W*g +: GRP_W]),
            .staged    (s_r.staged[GRP_W*g +: GRP_W]),
            .enable    (s_r.enable[GRP_W*g +: GRP_W]),
            .gap_mode  (s_r.gap_mode[g]),
            .hit_a     (hit_a),
            .hit_b     (hit_b),
            .latch_nxt (grp_latch[GRP_W*g +: GRP_W]),
            .moved     (grp_moved[g])
        );
    end

    always_comb begin
        s_nxt       = s_r;
        s_nxt.ack   = req;
        s_nxt.rdata = RDATA_NONE;

        // Register reads; unmapped offsets answer with zero
        if (rd) begin
            case (wb_adr_i)
                OFS_LATCH: begin
                    s_nxt.rdata = {16'h0000, s_r.latch};
                end
                OFS_FUNC_UP: begin
                    s_nxt.rdata = {16'h0000, s_r.func_up};
                end
                OFS_FUNC_LO: begin
                    s_nxt.rdata = {16'h0000, s_r.func_lo};
                end
                OFS_ENABLE: begin
                    s_nxt.rdata = {16'h0000, s_r.enable};
                end
                OFS_STAGED: begin
                    s_nxt.rdata = {16'h0000, s_r.staged};
                end
                OFS_TRIG_SEL: begin
                    s_nxt.rdata = {24'h00_0000, s_r.trig_sel};
                end
                OFS_GAP_MODE: begin
                    s_nxt.rdata = {24'h00_0000, GAP_MODE_RSVD, s_r.gap_mode};
                end
                OFS_PINS: begin
                    s_nxt.rdata = {s_r.oe, s_r.latch};
                end
                OFS_XFER_CNT: begin
                    s_nxt.rdata = {16'h0000, s_r.xfer_cnt};
                end
                default: begin
                    s_nxt.rdata = RDATA_NONE;
                end
            endcase
        end

        // Register writes; the latch write is folded into bus_latch
        if (wr) begin
            case (wb_adr_i)
                OFS_FUNC_UP: begin
                    s_nxt.func_up = merge16(s_r.func_up, wb_dat_i, wb_sel_i);
                end
                OFS_FUNC_LO: begin
                    s_nxt.func_lo = merge16(s_r.func_lo, wb_dat_i, wb_sel_i);
                end
                OFS_ENABLE: begin
                    s_nxt.enable = merge16(s_r.enable, wb_dat_i, wb_sel_i);
                end
                OFS_STAGED: begin
                    // Refill from processor or DMA alike
                    s_nxt.staged = merge16(s_r.staged, wb_dat_i, wb_sel_i);
                end
                OFS_TRIG_SEL: begin
                    s_nxt.trig_sel = merge8(s_r.trig_sel, wb_dat_i, wb_sel_i);
                end
                OFS_GAP_MODE: begin
                    if (wb_sel_i[0]) begin
                        s_nxt.gap_mode = wb_dat_i[3:0];
                    end
                end
                default: begin
                    s_nxt.rdata = RDATA_NONE;
                end
            endcase
        end

        // Staged-to-latch copy lands on this edge
        s_nxt.latch = grp_latch;

        // Count trigger events that moved any group; a write clears it,
        // but an event in the same cycle still counts
        if (wr && wb_adr_i == OFS_XFER_CNT) begin
            s_nxt.xfer_cnt = 16'h0000;
        end
        if (|grp_moved) begin
            s_nxt.xfer_cnt = s_nxt.xfer_cnt + 16'h0001;
        end

        // Drive only where function and enable both agree
        s_nxt.oe = func_on & s_r.enable;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= UNIT_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Level follows the latch even where the pin is not driven,
    // so software sees the value it will get once enabled
    assign pins.level = s_r.latch;
    assign pins.oe    = s_r.oe;
    assign wb_dat_o   = s_r.rdata;
    assign wb_ack_o   = s_r.ack;

endmodule : pattern_output_unit

// >>> tb/pattern_output_unit_props.sv
// Port checker of the pattern output unit
// Assumes binding to pattern_output_unit, single sys_clk domain
`timescale 1ns/1ps
module pattern_output_unit_props
    import pattern_pkg::*;
(
    input wire logic          sys_clk,
    input wire logic          rst_n,
    input wire logic          wb_cyc_i,
    input wire logic          wb_stb_i,
    input wire logic          wb_we_i,
    input wire logic          wb_ack_o,
    input wire logic [31:0]   wb_dat_o,
    input wire timer_evt_t    timer_evt,
    input wire pattern_pins_t pins
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic req;
    logic wr;
    logic quiet;
    assign req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr    = req && wb_we_i;
    // Bus writes may move the latch too
    assign quiet = !wr && !(|timer_evt);
    sequence b_only;
        !wr && (|timer_evt.match_b) && !(|timer_evt.match_a) && !(|timer_evt.capture_a);
    endsequence
    sequence evt_twice;
        (!wr && (|timer_evt)) ##1 (!wr && $stable(timer_evt));
    endsequence
    AST_ACK_NEXT: assert property (req |=> wb_ack_o)
        else $error("ack missing after request");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(req))
        else $error("ack without request");
    AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == '0)
        else $error("read data outside ack");
    AST_LEVEL_CAUSE: assert property ($changed(pins.level) |-> !$past(quiet))
        else $error("latch moved without cause");
    AST_B_NO_RISE: assert property (b_only |=> (pins.level & ~$past(pins.level)) == '0)
        else $error("rise on compare B");
    AST_TWICE: assert property (evt_twice |=> $stable(pins.level))
        else $error("repeat trigger changed latch");
    AST_OE_CAUSE: assert property ($changed(pins.oe) |-> $past(wb_ack_o))
        else $error("enable moved without access");
endmodule : pattern_output_unit_props

bind pattern_output_unit pattern_output_unit_props chk_u (.sys_clk(sys_clk), .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o), .timer_evt(timer_evt), .pins(pins));

// >>> tb/timer_model.sv
// Behavioural timer unit: one-cycle compare and capture strobes
// Assumes the bench raises a request for as many cycles as strobes wanted
`timescale 1ns/1ps
module timer_model
    import pattern_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire timer_evt_t req,
    output timer_evt_t      evt
);
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            evt <= '0;
        end else begin
            evt <= req;
        end
    end
endmodule : timer_model

// >>> tb/pattern_output_unit_tb_top.sv
// Self-checking bench of the pattern output unit
// Assumes the timer model on the event side, Wishbone tasks on the bus
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module pattern_output_unit_tb_top import pattern_pkg::*;;
    logic          sys_clk = 1'b0;
    logic          rst_n = 1'b0;
    logic          cyc = 1'b0;
    logic          stb = 1'b0;
    logic          we = 1'b0;
    logic [7:0]    adr = 8'h00;
    logic [3:0]    sel = 4'h0;
    logic [31:0]   dat = 32'h0000_0000;
    logic [31:0]   rdat;
    logic [31:0]   q;
    logic          ack;
    timer_evt_t    req = '0;
    timer_evt_t    evt;
    pattern_pins_t pins;
    int            num_errors = 0;
    int            tests_run = 0;
    logic [7:0]    prev;
    logic [15:0]   lvl;
    logic [7:0]    five [8] = '{8'h80, 8'hC0, 8'h40, 8'h60, 8'h20, 8'h30, 8'h10, 8'h18};
    logic [7:0]    four [4] = '{8'h95, 8'h65, 8'h59, 8'h56};

    always #2.5 sys_clk = ~sys_clk;

    timer_model tm_u (.sys_clk(sys_clk), .rst_n(rst_n), .req(req), .evt(evt));
    pattern_output_unit dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .timer_evt(evt), .pins(pins));

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hF;
        do @(posedge sys_clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        `CHK(q, e)
    endtask : rd

    // Strobe count n lets two triggers arrive back to back
    task automatic fire(input timer_evt_t e, input int n = 1);
        @(posedge sys_clk);
        req <= e;
        repeat (n) @(posedge sys_clk);
        req <= '0;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask : fire

    task automatic complete_run();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (5000) @(posedge sys_clk);
        num_errors++;
        complete_run();
    end

    initial begin
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(OFS_TRIG_SEL, 32'h0000_00FF);
        rd(OFS_GAP_MODE, 32'h0000_00F0);
        rd(OFS_PINS, 32'h0000_0000);
        rd(8'h40, 32'h0000_0000);
        bus(1'b1, OFS_FUNC_UP, 32'h0000_FFC0);
        bus(1'b1, OFS_ENABLE, 32'h0000_F800);
        rd(OFS_FUNC_UP, 32'h0000_FFC0);
        rd(OFS_ENABLE, 32'h0000_F800);
        prev = 8'h00;
        foreach (five[i]) begin
            bus(1'b1, OFS_STAGED, {16'h0000, five[i] | 8'h07, 8'hFF});
            fire(12'h080);
            `CHK(pins.level, {prev, 8'h00})
            fire(i % 2 ? 12'h008 : 12'h800);
            prev = five[i] & 8'hF8;
            `CHK(pins, {prev, 8'h00, 16'hF800})
        end
        bus(1'b1, OFS_FUNC_LO, 32'h0000_FFFF);
        bus(1'b1, OFS_ENABLE, 32'h0000_FFFF);
        lvl = {prev, 8'h00};
        for (int ch = 0; ch < 4; ch++) begin
            bus(1'b1, OFS_TRIG_SEL, {24'h00_0000, {4{ch[1:0]}}});
            bus(1'b1, OFS_STAGED, {16'h0000, 16'h1111 << ch});
            fire(12'h100 << ((ch + 1) % 4));
            `CHK(pins.level, lvl)
            fire(12'h100 << ch, 2);
            lvl = 16'h1111 << ch;
            `CHK(pins.level, lvl)
        end
        rd(OFS_PINS, {16'hF8FF, lvl});
        // Eight single moves, then four double strobes
        rd(OFS_XFER_CNT, 32'h0000_0010);
        bus(1'b1, OFS_XFER_CNT, 32'h0000_0000);
        bus(1'b1, OFS_LATCH, 32'h0000_0000);
        bus(1'b1, OFS_FUNC_UP, 32'h0000_FFFF);
        bus(1'b1, OFS_ENABLE, 32'h0000_FF00);
        bus(1'b1, OFS_TRIG_SEL, 32'h0000_00FF);
        bus(1'b1, OFS_GAP_MODE, 32'h0000_000C);
        rd(OFS_GAP_MODE, 32'h0000_00FC);
        prev = 8'h00;
        foreach (four[i]) begin
            bus(1'b1, OFS_STAGED, {16'h0000, four[i], 8'h00});
            fire(12'h080);
            `CHK(pins.level, {prev & four[i], 8'h00})
            fire(12'h800);
            `CHK(pins.level, {four[i], 8'h00})
            prev = four[i];
        end
        rd(OFS_XFER_CNT, 32'h0000_0008);
        rd(OFS_LATCH, 32'h0000_5600);
        complete_run();
    end
endmodule : pattern_output_unit_tb_top
